// *** include/rxd_regs.vh ***
`ifndef RXD_REGS_VH
`define RXD_REGS_VH

// ----------------
// Register offsets (byte addresses on the register bus)
// ----------------
`define RXD_OFS_CTRL 8'h00
`define RXD_OFS_RX_BASE 8'h04
`define RXD_OFS_TX_BASE 8'h08
`define RXD_OFS_IRQ 8'h0c
`define RXD_OFS_CUR_DESC 8'h10
`define RXD_OFS_STATE 8'h14

// ----------------
// Control and interrupt status bits
// ----------------
`define RXD_CTRL_RUN 0
`define RXD_CTRL_POLL 1
`define RXD_IRQ_WDOG 9

// ----------------
// Receive descriptor word 0 fields
// ----------------
`define RXD_W0_OWN 31
`define RXD_W0_MISMATCH 30
`define RXD_W0_LEN_MSB 29
`define RXD_W0_LEN_LSB 16
`define RXD_W0_ERRSUM 15
`define RXD_W0_UNAVAIL 14
`define RXD_W0_LOOP_MSB 13
`define RXD_W0_LOOP_LSB 12
`define RXD_W0_SHORT 11
`define RXD_W0_GROUP 10
`define RXD_W0_FIRST 9
`define RXD_W0_LAST 8
`define RXD_W0_LONG 7
`define RXD_W0_LATE 6
`define RXD_W0_TYPE 5
`define RXD_W0_WDOG 4
`define RXD_W0_PHY 3
`define RXD_W0_MISALIGN 2
`define RXD_W0_CRC 1
`define RXD_W0_OVF 0

// ----------------
// Receive descriptor word 1 fields
// ----------------
`define RXD_W1_BOTTOM 25
`define RXD_W1_CHAIN 24
`define RXD_W1_B2_MSB 21
`define RXD_W1_B2_LSB 11
`define RXD_W1_B1_MSB 10
`define RXD_W1_B1_LSB 0

// ----------------
// Sizes, limits and reset values
// ----------------
`define RXD_DESC_STRIDE 32'h00000010
`define RXD_SHORT_LIMIT 14'h0040
`define RXD_LONG_LIMIT 14'h05ee
`define RXD_BASE_RESET 32'h00000000

`endif

// *** src/rxd_desc_manager.v ***
// Notes on behaviour
// - Host loads rx and tx list bases; fetching starts at the rx base.
// - Ring layout: descriptors back to back, two buffers, wrap at bottom.
// - Chain layout: one buffer, fourth word points to next descriptor.
// - Ring and chain descriptors may mix; each picks its own successor.
// - A receive descriptor is four 32-bit words.
// - Ownership bit 1 means device, 0 host; device clears it on close.
// - Frame byte count goes into the status word.
// - Address mismatch flag set when the filter did not match.
// - Status written after the buffer fills; meaningful in last segment.
// - Error summary bit 15 ORs unavailable, short, long, late, CRC, overflow.
// - Bit 14 set when a frame is cut short for lack of a buffer.
// - Bits 13:12 give the frame origin: normal, internal or external loop.
// - Bit 11 set for frames under 64 bytes, unless overflow occurred.
// - Bit 10 set for a multicast destination.
// - Bit 9 marks the first segment, bit 8 the last segment.
// - Bit 7 set for frames longer than 1518 bytes.
// - Bit 6 set on a late collision during reception.
// - Bit 5 set for type frames, clear for length frames.
// - Bit 4 and interrupt status bit 9 set on receive watchdog timeout.
// - Bit 3 on a physical layer error, bit 2 on a misaligned end.
// - Bit 1 set on a CRC failure.
// - Bit 0 set on receive FIFO overflow.
// - Word 1 bit 25 marks the list bottom; next is the list base.
// - Word 1 bit 24 makes word 3 the next descriptor address.
// - Second buffer size from word 1 bits 21:11, ignored when chained.
// - A host-owned descriptor suspends reception until the host returns one.
`timescale 1ns/10ps
`include "rxd_regs.vh"

module rxd_desc_manager (
    // Clock and reset
    input wire clock,
    input wire rst,
    // APB register port
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Host memory master port, one word per request
    output reg memReq,
    output reg memWrite,
    output reg [31:0] memAddr,
    output reg [31:0] memWdata,
    input wire memAck,
    input wire [31:0] memRdata,
    // Received frame summary from the MAC
    input wire rxFrameValid,
    output reg rxFrameReady,
    input wire [13:0] rxFrameLength,
    input wire rxAddrMismatch,
    input wire [1:0] rxLoopMode,
    input wire rxMulticast,
    input wire rxLateColl,
    input wire rxTypeFrame,
    input wire rxWatchdog,
    input wire rxPhyErr,
    input wire rxDribble,
    input wire rxCrcErr,
    input wire rxOverflow
);

    // ----------------
    // States
    // ----------------
    localparam [5:0] ST_STOP = 6'h01;
    localparam [5:0] ST_FETCH = 6'h02;
    localparam [5:0] ST_HAVE = 6'h04;
    localparam [5:0] ST_CONSUME = 6'h08;
    localparam [5:0] ST_CLOSE = 6'h10;
    localparam [5:0] ST_SUSP = 6'h20;

    // What follows a status write
    localparam [1:0] AF_CONT = 2'h0;
    localparam [1:0] AF_SUSP = 2'h1;
    localparam [1:0] AF_NEW = 2'h2;

    // ----------------
    // Storage
    // ----------------
    reg [5:0] state;
    reg runEnable;
    reg pollPulse;
    reg irqWdog;
    reg [31:0] rxListBase;
    reg [31:0] txListBase;
    reg [31:0] curDesc;
    reg [31:0] closeAddr;
    reg [31:0] descWord1;
    reg [31:0] descWord3;
    reg [1:0] wordIdx;
    reg [1:0] afterClose;
    reg [13:0] remaining;
    reg midFrame;
    reg pendClose;
    reg firstSeg;
    reg closeFirst;
    reg closeLast;
    reg closeTrunc;
    reg prevValid;
    // Frame summary latched when the frame is taken
    reg [13:0] fLen;
    reg fMismatch;
    reg [1:0] fLoop;
    reg fGroup;
    reg fLate;
    reg fType;
    reg fWdog;
    reg fPhy;
    reg fMisalign;
    reg fCrc;
    reg fOvf;

    // ----------------
    // Derived values
    // ----------------
    wire apbAccess = psel & penable & pready;
    wire apbWrite = apbAccess & pwrite;
    wire isChain = descWord1[`RXD_W1_CHAIN];
    wire [10:0] buf1Size = descWord1[`RXD_W1_B1_MSB:`RXD_W1_B1_LSB];
    // Second buffer only counts in ring layout
    wire [10:0] buf2Size = isChain ? 11'h000 :
        descWord1[`RXD_W1_B2_MSB:`RXD_W1_B2_LSB];
    wire [13:0] capacity = {3'h0, buf1Size} + {3'h0, buf2Size};
    reg [31:0] nextDesc;
    reg [31:0] statusWord;
    reg [31:0] readValue;
    reg readHit;
    wire isShort = (fLen < `RXD_SHORT_LIMIT) & ~fOvf;
    wire isLong = fLen > `RXD_LONG_LIMIT;
    wire errSum = closeTrunc | isShort | isLong | fLate | fCrc | fOvf;

    // Successor chosen by this descriptor's own layout bits
    always @* begin
        if (descWord1[`RXD_W1_BOTTOM]) begin
            nextDesc = rxListBase;
        end else if (isChain) begin
            nextDesc = {descWord3[31:2], 2'h0};
        end else begin
            nextDesc = curDesc + `RXD_DESC_STRIDE;
        end
    end

    // Status word; frame flags only go into the last segment
    always @* begin
        statusWord = 32'h00000000;
        statusWord[`RXD_W0_OWN] = 1'b0;
        statusWord[`RXD_W0_FIRST] = closeFirst;
        statusWord[`RXD_W0_LAST] = closeLast;
        if (closeLast) begin
            statusWord[`RXD_W0_LEN_MSB:`RXD_W0_LEN_LSB] = fLen;
            statusWord[`RXD_W0_MISMATCH] = fMismatch;
            statusWord[`RXD_W0_ERRSUM] = errSum;
            statusWord[`RXD_W0_UNAVAIL] = closeTrunc;
            statusWord[`RXD_W0_LOOP_MSB:`RXD_W0_LOOP_LSB] = fLoop;
            statusWord[`RXD_W0_SHORT] = isShort;
            statusWord[`RXD_W0_GROUP] = fGroup;
            statusWord[`RXD_W0_LONG] = isLong;
            statusWord[`RXD_W0_LATE] = fLate;
            statusWord[`RXD_W0_TYPE] = fType;
            statusWord[`RXD_W0_WDOG] = fWdog;
            statusWord[`RXD_W0_PHY] = fPhy;
            statusWord[`RXD_W0_MISALIGN] = fMisalign;
            statusWord[`RXD_W0_CRC] = fCrc;
            statusWord[`RXD_W0_OVF] = fOvf;
        end
    end

    // ----------------
    // Register read decode
    // ----------------
    always @* begin
        readValue = 32'h00000000;
        readHit = 1'b1;
        case (paddr)
            `RXD_OFS_CTRL: readValue[`RXD_CTRL_RUN] = runEnable;
            `RXD_OFS_RX_BASE: readValue = rxListBase;
            `RXD_OFS_TX_BASE: readValue = txListBase;
            `RXD_OFS_IRQ: readValue[`RXD_IRQ_WDOG] = irqWdog;
            `RXD_OFS_CUR_DESC: readValue = curDesc;
            `RXD_OFS_STATE: readValue = {26'h0000000, state};
            default: readHit = 1'b0;
        endcase
    end

    // ----------------
    // APB slave: one wait-free access phase per transfer
    // ----------------
    always @(posedge clock) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            runEnable <= 1'b0;
            pollPulse <= 1'b0;
            rxListBase <= `RXD_BASE_RESET;
            txListBase <= `RXD_BASE_RESET;
        end else begin
            // Answer is prepared in the setup cycle, so no wait states
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~readHit;
            prdata <= (psel & ~penable & ~pwrite) ? readValue : 32'h00000000;
            pollPulse <= apbWrite & (paddr == `RXD_OFS_CTRL) &
                pwdata[`RXD_CTRL_POLL];
            if (apbWrite) begin
                case (paddr)
                    `RXD_OFS_CTRL: runEnable <= pwdata[`RXD_CTRL_RUN];
                    // Bases are word aligned; low bits are dropped
                    `RXD_OFS_RX_BASE: rxListBase <= {pwdata[31:2], 2'h0};
                    `RXD_OFS_TX_BASE: txListBase <= {pwdata[31:2], 2'h0};
                    default: ;
                endcase
            end
        end
    end

    // ----------------
    // Watchdog interrupt flag: write one to clear, a new event wins
    // ----------------
    always @(posedge clock) begin
        if (rst) begin
            irqWdog <= 1'b0;
        end else if (state == ST_CLOSE && memReq && memAck && closeLast &&
                     fWdog) begin
            irqWdog <= 1'b1;
        end else if (apbWrite && paddr == `RXD_OFS_IRQ &&
                     pwdata[`RXD_IRQ_WDOG]) begin
            irqWdog <= 1'b0;
        end
    end

    // ----------------
    // Descriptor walker
    // ----------------
    always @(posedge clock) begin
        if (rst) begin
            state <= ST_STOP;
            memReq <= 1'b0;
            memWrite <= 1'b0;
            memAddr <= 32'h00000000;
            memWdata <= 32'h00000000;
            rxFrameReady <= 1'b0;
            curDesc <= `RXD_BASE_RESET;
            closeAddr <= 32'h00000000;
            descWord1 <= 32'h00000000;
            descWord3 <= 32'h00000000;
            wordIdx <= 2'h0;
            afterClose <= AF_CONT;
            remaining <= 14'h0000;
            midFrame <= 1'b0;
            pendClose <= 1'b0;
            firstSeg <= 1'b0;
            closeFirst <= 1'b0;
            closeLast <= 1'b0;
            closeTrunc <= 1'b0;
            prevValid <= 1'b0;
            fLen <= 14'h0000;
            fMismatch <= 1'b0;
            fLoop <= 2'h0;
            fGroup <= 1'b0;
            fLate <= 1'b0;
            fType <= 1'b0;
            fWdog <= 1'b0;
            fPhy <= 1'b0;
            fMisalign <= 1'b0;
            fCrc <= 1'b0;
            fOvf <= 1'b0;
        end else begin
            prevValid <= rxFrameValid;
            case (state)
                // Stopped until software sets the run bit
                ST_STOP: begin
                    if (runEnable) begin
                        curDesc <= rxListBase;
                        wordIdx <= 2'h0;
                        state <= ST_FETCH;
                    end
                end
                // Read the four descriptor words in order
                ST_FETCH: begin
                    if (!memReq) begin
                        memReq <= 1'b1;
                        memWrite <= 1'b0;
                        memAddr <= curDesc + {28'h0000000, wordIdx, 2'h0};
                    end else if (memAck) begin
                        memReq <= 1'b0;
                        case (wordIdx)
                            2'h0: begin
                                if (!memRdata[`RXD_W0_OWN]) begin
                                    if (pendClose) begin
                                        // Frame cut short, close as last
                                        closeLast <= 1'b1;
                                        closeTrunc <= 1'b1;
                                        afterClose <= AF_SUSP;
                                        state <= ST_CLOSE;
                                    end else begin
                                        state <= ST_SUSP;
                                    end
                                end else begin
                                    wordIdx <= 2'h1;
                                    if (pendClose) begin
                                        // Previous segment handed back now
                                        closeLast <= 1'b0;
                                        closeTrunc <= 1'b0;
                                        afterClose <= AF_CONT;
                                        state <= ST_CLOSE;
                                    end
                                end
                            end
                            2'h1: begin
                                descWord1 <= memRdata;
                                wordIdx <= 2'h2;
                            end
                            // Buffer address not used: no data is moved
                            2'h2: wordIdx <= 2'h3;
                            default: begin
                                descWord3 <= memRdata;
                                wordIdx <= 2'h0;
                                if (midFrame) begin
                                    state <= ST_CONSUME;
                                end else begin
                                    rxFrameReady <= 1'b1;
                                    state <= ST_HAVE;
                                end
                            end
                        endcase
                    end
                end
                // Descriptor in hand, wait for the next frame
                ST_HAVE: begin
                    if (!runEnable) begin
                        rxFrameReady <= 1'b0;
                        state <= ST_STOP;
                    end else if (rxFrameValid && rxFrameReady) begin
                        rxFrameReady <= 1'b0;
                        fLen <= rxFrameLength;
                        fMismatch <= rxAddrMismatch;
                        fLoop <= rxLoopMode;
                        fGroup <= rxMulticast;
                        fLate <= rxLateColl;
                        fType <= rxTypeFrame;
                        fWdog <= rxWatchdog;
                        fPhy <= rxPhyErr;
                        fMisalign <= rxDribble;
                        fCrc <= rxCrcErr;
                        fOvf <= rxOverflow;
                        remaining <= rxFrameLength;
                        midFrame <= 1'b1;
                        firstSeg <= 1'b1;
                        state <= ST_CONSUME;
                    end
                end
                // Account the frame against this descriptor's buffers
                ST_CONSUME: begin
                    closeAddr <= curDesc;
                    closeFirst <= firstSeg;
                    firstSeg <= 1'b0;
                    curDesc <= nextDesc;
                    if (remaining <= capacity) begin
                        // Frame ends here; close then prefetch the next one
                        remaining <= 14'h0000;
                        closeLast <= 1'b1;
                        closeTrunc <= 1'b0;
                        afterClose <= AF_NEW;
                        state <= ST_CLOSE;
                    end else begin
                        // Spans on; hold this close until the next is owned
                        remaining <= remaining - capacity;
                        pendClose <= 1'b1;
                        wordIdx <= 2'h0;
                        state <= ST_FETCH;
                    end
                end
                // Single write of word 0 carries status and ownership
                ST_CLOSE: begin
                    if (!memReq) begin
                        memReq <= 1'b1;
                        memWrite <= 1'b1;
                        memAddr <= closeAddr;
                        memWdata <= statusWord;
                    end else if (memAck) begin
                        memReq <= 1'b0;
                        memWrite <= 1'b0;
                        pendClose <= 1'b0;
                        if (closeLast) begin
                            midFrame <= 1'b0;
                        end
                        case (afterClose)
                            AF_SUSP: state <= ST_SUSP;
                            AF_NEW: begin
                                wordIdx <= 2'h0;
                                state <= ST_FETCH;
                            end
                            default: state <= ST_FETCH;
                        endcase
                    end
                end
                // Suspended; retry on a poll demand or a new frame
                ST_SUSP: begin
                    if (!runEnable) begin
                        state <= ST_STOP;
                    end else if (pollPulse || (rxFrameValid && !prevValid)) begin
                        wordIdx <= 2'h0;
                        state <= ST_FETCH;
                    end
                end
                default: state <= ST_STOP;
            endcase
        end
    end

endmodule

// *** tb/rxd_desc_manager_properties.sv ***
`timescale 1ns/10ps
module rxd_props (
    // Clock and reset
    input wire clock,
    input wire rst,
    // Register bus
    input wire psel,
    input wire penable,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // Host memory port
    input wire memReq,
    input wire memWrite,
    input wire [31:0] memAddr,
    input wire [31:0] memWdata,
    input wire memAck,
    // Frame port
    input wire rxFrameValid,
    input wire rxFrameReady
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // Status write; only word 0 is written
    wire st = memReq && memWrite;
    wire stl = st && memWdata[8];

    a_apb_no_wait: assert property (psel && !penable |=> pready)
        else $error("no pready");
    a_ready_setup: assert property (pready |-> $past(psel && !penable))
        else $error("stray pready");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("stray pslverr");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not 0");
    a_mem_hold: assert property (memReq && !memAck |=> memReq &&
        $stable(memAddr) && $stable(memWrite) && $stable(memWdata))
        else $error("request moved");
    a_mem_gap: assert property (memReq && memAck |=> !memReq)
        else $error("no idle gap");
    a_word_align: assert property (memReq |-> memAddr[1:0] == 2'b00)
        else $error("unaligned");
    a_close_owner: assert property (st |-> !memWdata[31])
        else $error("owner kept");
    a_err_summary: assert property (stl |-> memWdata[15] ==
        |{memWdata[14], memWdata[11], memWdata[7:6], memWdata[1:0]})
        else $error("bad summary");
    a_short_len: assert property (stl && !memWdata[0] |->
        memWdata[11] == (memWdata[29:16] < 14'h0040))
        else $error("bad short");
    a_short_ovf: assert property (stl && memWdata[0] |-> !memWdata[11])
        else $error("short on ovf");
    a_long_len: assert property (stl |->
        memWdata[7] == (memWdata[29:16] > 14'h05ee))
        else $error("bad long");
    a_loop_code: assert property (stl |-> memWdata[13:12] != 2'b11)
        else $error("bad origin");
    a_mid_clean: assert property (st && !memWdata[8] |->
        memWdata[31:10] == 22'h0 && memWdata[7:0] == 8'h00)
        else $error("mid status");
    a_take_once: assert property (rxFrameValid && rxFrameReady |=> !rxFrameReady)
        else $error("ready held");

    c_refused: cover property (pready && pslverr);
    c_trunc: cover property (stl && memWdata[14]);
    c_multi: cover property (st && memWdata[9] && !memWdata[8]);
    c_take: cover property (rxFrameValid && rxFrameReady);
endmodule

bind rxd_desc_manager rxd_props i_props (.clock(clock), .rst(rst),
    .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .memReq(memReq), .memWrite(memWrite),
    .memAddr(memAddr), .memWdata(memWdata), .memAck(memAck),
    .rxFrameValid(rxFrameValid), .rxFrameReady(rxFrameReady));

// *** tb/rxd_host_mem.sv ***
`timescale 1ns/10ps
module rxd_host_mem (
    // Clock and reset
    input wire clock,
    input wire rst,
    // Memory slave port
    input wire memReq,
    input wire memWrite,
    input wire [31:0] memAddr,
    input wire [31:0] memWdata,
    output reg memAck,
    output reg [31:0] memRdata
);
    reg [31:0] mem [0:1023];
    reg [2:0] waitCnt;
    reg [3:0] pace;
    // Varying delay; idle data inverted
    always @(posedge clock) begin
        if (rst) begin
            memAck <= 1'b0;
            memRdata <= 32'h5a5a5a5a;
            waitCnt <= 3'h0;
            pace <= 4'h0;
        end else if (memReq && memAck) begin
            if (memWrite) begin
                mem[memAddr[11:2]] <= memWdata;
            end
            memAck <= 1'b0;
            memRdata <= ~memRdata;
            waitCnt <= 3'h0;
            pace <= pace + 4'h5;
        end else if (memReq) begin
            if (waitCnt >= {1'b0, pace[1:0]}) begin
                memAck <= 1'b1;
                memRdata <= mem[memAddr[11:2]];
            end
            waitCnt <= waitCnt + 3'h1;
        end else begin
            memAck <= 1'b0;
            memRdata <= ~memRdata;
        end
    end
endmodule

// *** tb/rx_descriptor_buffer_manager_tb.sv ***
`timescale 1ns/10ps
`include "rxd_regs.vh"
module rx_descriptor_buffer_manager_tb;
    reg clock = 1'b0;
    reg rst = 1'b1;
    reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rxFrameValid = 1'b0;
    reg [7:0] paddr = 8'h00, rnd = 8'h3d;
    reg [31:0] pwdata = 32'h0, rd;
    reg [13:0] rxFrameLength = 14'h0000, len;
    reg [1:0] rxLoopMode = 2'h0;
    reg [8:0] fl = 9'h000, f;
    reg err;
    reg [31:0] da [0:2], dw1 [0:2], dw3 [0:2];
    wire [31:0] prdata, memAddr, memWdata, memRdata;
    wire pready, pslverr, memReq, memWrite, memAck, rxFrameReady;
    integer num_errors = 0, n_tests = 0, d, i, k;

    always #2.5 clock = ~clock;

    rxd_desc_manager i_dut (.clock(clock), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .memReq(memReq),
        .memWrite(memWrite), .memAddr(memAddr), .memWdata(memWdata),
        .memAck(memAck), .memRdata(memRdata), .rxFrameValid(rxFrameValid),
        .rxFrameReady(rxFrameReady), .rxFrameLength(rxFrameLength),
        .rxAddrMismatch(fl[8]), .rxLoopMode(rxLoopMode), .rxMulticast(fl[7]),
        .rxLateColl(fl[6]), .rxTypeFrame(fl[5]), .rxWatchdog(fl[4]),
        .rxPhyErr(fl[3]), .rxDribble(fl[2]), .rxCrcErr(fl[1]),
        .rxOverflow(fl[0]));
    rxd_host_mem i_mem (.clock(clock), .rst(rst), .memReq(memReq),
        .memWrite(memWrite), .memAddr(memAddr), .memWdata(memWdata),
        .memAck(memAck), .memRdata(memRdata));

    // ----------------
    // Expectations and checks
    // ----------------
    function [7:0] lfsr(input [7:0] s);
        lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // Status word of a closed last segment; f = mism,mc,late,type,wd,phy,al,crc,ovf
    function [31:0] status(input [13:0] n, input [8:0] f, input [1:0] lp,
        input first, input cut);
        reg sh, lg;
        begin
            sh = n < 14'h0040 && !f[0];
            lg = n > 14'h05ee;
            status = {1'b0, f[8], n, cut | sh | lg | f[6] | f[1] | f[0], cut,
                lp, sh, f[7], first, 1'b1, lg, f[6:0]};
        end
    endfunction
    task summarize;
        begin
            $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
            if (num_errors == 0 && n_tests > 0) begin
                $display("All tests passed");
            end else begin
                $display("Some tests failed");
            end
            $finish;
        end
    endtask
    task timeout;
        begin
            num_errors = num_errors + 1;
            $display("Error at %0t: wait ran out", $time);
            summarize;
        end
    endtask
    task check(input [32:0] got, input [32:0] want);
        begin
            n_tests = n_tests + 1;
            if (got !== want) begin
                num_errors = num_errors + 1;
                $display("Error at %0t: got %h want %h", $time, got, want);
            end
        end
    endtask

    // ----------------
    // Drivers
    // ----------------
    task apb(input wr, input [7:0] a, input [31:0] wd);
        begin
            @(posedge clock);
            {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, wd};
            @(posedge clock);
            penable <= 1'b1;
            for (d = 0; d < 20 && !(pready && penable); d = d + 1)
                @(posedge clock);
            if (d == 20) timeout;
            rd = prdata;
            err = pslverr;
            {psel, penable} <= 2'b00;
        end
    endtask
    task frame(input [13:0] n, input [1:0] lp);
        begin
            @(posedge clock);
            {rxFrameValid, rxFrameLength, fl, rxLoopMode} <= {1'b1, n, f, lp};
            for (d = 0; d < 300 && !(rxFrameReady && rxFrameValid); d = d + 1)
                @(posedge clock);
            if (d == 300) timeout;
            rxFrameValid <= 1'b0;
        end
    endtask
    // Host returns a descriptor
    task own(input integer n);
        begin
            i_mem.mem[da[n][11:2]] = 32'h80000000;
            i_mem.mem[da[n][11:2] + 10'h1] = dw1[n];
            i_mem.mem[da[n][11:2] + 10'h2] = da[n] + 32'h1000;
            i_mem.mem[da[n][11:2] + 10'h3] = dw3[n];
        end
    endtask
    task closed(input integer n, input [31:0] want);
        begin
            for (d = 0; d < 400 && i_mem.mem[da[n][11:2]][31]; d = d + 1)
                @(posedge clock);
            if (d == 400) timeout;
            check(i_mem.mem[da[n][11:2]], want);
        end
    endtask
    task susp;
        begin
            for (i = 0; i < 40; i = i + 1) begin
                apb(1'b0, `RXD_OFS_STATE, 32'h0);
                if (rd === 32'h20) i = 40;
            end
            check({err, rd}, 33'h20);
        end
    endtask
    task rand_f;
        begin
            rnd = lfsr(rnd);
            f = {rnd[2], rnd};
        end
    endtask

    // Ring, chained and bottom descriptors
    initial begin
        da[0] = 32'h100;
        da[1] = 32'h110;
        da[2] = 32'h300;
        dw1[0] = 32'h00032064;
        dw1[1] = 32'h013e80c8; // Chained: size 2 ignored
        dw1[2] = 32'h020fa3e8;
        dw3[0] = 32'h0;
        dw3[1] = 32'h300;
        dw3[2] = 32'h0;
        for (k = 0; k < 3; k = k + 1) own(k);
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        apb(1'b0, `RXD_OFS_RX_BASE, 32'h0);
        check({err, rd}, {1'b0, `RXD_BASE_RESET});
        apb(1'b0, `RXD_OFS_STATE, 32'h0);
        check({err, rd}, 33'h1);
        apb(1'b0, 8'h18, 32'h0);
        check({err, rd}, 33'h100000000);
        apb(1'b1, `RXD_OFS_RX_BASE, da[0]);
        apb(1'b1, `RXD_OFS_TX_BASE, 32'h800);
        apb(1'b0, `RXD_OFS_TX_BASE, 32'h0);
        check({err, rd}, 33'h800);
        apb(1'b1, `RXD_OFS_CTRL, 32'h1);
        rand_f;
        frame(14'h0096, 2'h0);
        closed(0, status(14'h0096, f, 2'h0, 1'b1, 1'b0));
        rand_f;
        f[4] = 1'b1;
        frame(14'h0640, 2'h1);
        closed(2, status(14'h0640, f, 2'h1, 1'b0, 1'b0));
        check(i_mem.mem[10'h044], 33'h200);
        susp;
        apb(1'b0, `RXD_OFS_CUR_DESC, 32'h0);
        check({err, rd}, {1'b0, da[0]});
        apb(1'b0, `RXD_OFS_IRQ, 32'h0);
        check({err, rd}, 33'h200);
        apb(1'b1, `RXD_OFS_IRQ, 32'h200);
        apb(1'b0, `RXD_OFS_IRQ, 32'h0);
        check({err, rd}, 33'h0);
        own(0);
        apb(1'b1, `RXD_OFS_CTRL, 32'h3);
        rand_f;
        frame(14'h00fa, 2'h2);
        closed(0, status(14'h00fa, f, 2'h2, 1'b1, 1'b1));
        susp;
        for (k = 0; k < 3; k = k + 1) own(k);
        apb(1'b1, `RXD_OFS_CTRL, 32'h3);
        // Random frames, short limit corners first
        for (k = 1; k < 16; k = k + 1) begin
            rand_f;
            i = k % 3;
            len = {6'h00, rnd} % 14'h00c8 + 14'h0001;
            if (k < 3) len = 14'h003e + k[13:0];
            frame(len, i[1:0]);
            closed(i, status(len, f, i[1:0], 1'b1, 1'b0));
            own(i);
        end
        summarize;
    end
endmodule
